// >>> rtl/mct_translator.sv
`timescale 1ns/1ps
`default_nettype none
module mct_translator #(
  parameter int BEMF_WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic stepPulseInput,
  input wire logic directionPin,
  // configuration
  input wire logic [2:0] stepResolutionSelect,
  input wire logic directionControlBit,
  input wire logic stepEdgePolarityBit,
  input wire logic [4:0] peakCurrentCode,
  input wire logic backemfTransparencyBit,
  // regulator timing and coil voltage
  input wire logic pwmPeriodStart,
  input wire logic [BEMF_WIDTH-1:0] coilVoltage,
  // translator status
  output logic [6:0] translatorIndex,
  output var mct_pkg::mct_mode_type activeResolution,
  output logic stepTaken,
  // coil setpoints
  output logic signed [10:0] coilCurrentX,
  output logic signed [10:0] coilCurrentY,
  output logic [9:0] peakCurrentMa,
  output logic [1:0] lowSideRange,
  // back-emf
  output logic zeroCrossing,
  output logic [BEMF_WIDTH-1:0] backemfOutput
);
  import mct_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] stepSync;
  logic [2:0] dirSync;
  logic stepLevel;
  logic stepLevelPrev;
  logic dirLevel;
  logic [2:0] armCount;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stepSync <= 3'h0;
      dirSync <= 3'h0;
    end else begin
      stepSync <= {stepSync[1:0], stepPulseInput};
      dirSync <= {dirSync[1:0], directionPin};
    end
  end

  // a change counts only once the second and third stages agree
  wire stepAgree = stepSync[1] == stepSync[2];
  wire dirAgree = dirSync[1] == dirSync[2];
  wire armed = armCount == MCT_ARM_COUNT;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stepLevel <= 1'b0;
      dirLevel <= 1'b0;
      stepLevelPrev <= 1'b0;
    end else begin
      stepLevel <= stepAgree ? stepSync[2] : stepLevel;
      dirLevel <= dirAgree ? dirSync[2] : dirLevel;
      stepLevelPrev <= stepLevel;
    end
  end

  // edges are ignored until the synchroniser is filled, so an idle-high
  // pin does not fake a step just after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armCount <= 3'h0;
    end else if (!armed) begin
      armCount <= armCount + 3'h1;
    end
  end

  // ****************************************
  // trigger and direction
  // ****************************************
  wire stepRise = stepLevel & ~stepLevelPrev;
  wire stepFall = ~stepLevel & stepLevelPrev;
  wire trigger = armed &
                 (stepEdgePolarityBit ? stepFall : stepRise); // RULE6
  wire stepDown = dirLevel ^ directionControlBit; // RULE4 RULE21

  // ****************************************
  // index arithmetic and resynchronisation
  // ****************************************
  // an unused code keeps the mode already running
  wire selLegal = stepResolutionSelect != MCT_MODE_BAD;
  wire [2:0] pendingMode = selLegal ? stepResolutionSelect :
                           3'(activeResolution);
  wire [6:0] activeInc = mct_step_of(3'(activeResolution));
  wire [6:0] newInc = mct_step_of(pendingMode); // RULE2
  wire finer = newInc < activeInc;
  wire [6:0] halfInc = newInc >> 1;
  wire [6:0] roundedIdx = translatorIndex + halfInc;
  wire [6:0] snapIdx = roundedIdx & ~(newInc - 7'h01); // RULE9
  // coarser modes step from where they stand, offset kept
  wire [6:0] baseIdx = finer ? snapIdx : translatorIndex; // RULE10 RULE11
  // seven-bit arithmetic wraps both ways
  wire [6:0] next_index = stepDown ? baseIdx - newInc :
                          baseIdx + newInc; // RULE5 RULE20

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      translatorIndex <= MCT_INDEX_RESET; // RULE18
      activeResolution <= MCT_MODE_32; // RULE18
      stepTaken <= 1'b0;
    end else begin
      stepTaken <= trigger;
      if (trigger) begin
        translatorIndex <= next_index; // RULE1 RULE7
        activeResolution <= mct_mode_type'(pendingMode); // RULE8
      end
    end
  end

  // ****************************************
  // current lookup
  // ****************************************
  mct_coil_if coilBus ();
  assign coilBus.index = translatorIndex;
  assign coilBus.mode = 3'(activeResolution);

  mct_sine_lut lookupTable (
    .coil(coilBus.lookup)
  );

  wire zeroNow = coilBus.coilX == 11'sh000 ||
                 coilBus.coilY == 11'sh000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coilCurrentX <= 11'sh000;
      coilCurrentY <= 11'sh3E8;
    end else begin
      coilCurrentX <= coilBus.coilX; // RULE3
      coilCurrentY <= coilBus.coilY; // RULE3
    end
  end

  // ****************************************
  // peak current
  // ****************************************
  logic [4:0] appliedCode;
  wire [1:0] rangeOfCode = (appliedCode >= MCT_RANGE3_LO) ? 2'h3 :
                           (appliedCode >= MCT_RANGE2_LO) ? 2'h2 :
                           (appliedCode >= MCT_RANGE1_LO) ? 2'h1 : 2'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      appliedCode <= MCT_CODE_RESET;
    end else if (pwmPeriodStart) begin
      appliedCode <= peakCurrentCode; // RULE13
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      peakCurrentMa <= 10'h000;
      lowSideRange <= 2'h0;
    end else begin
      peakCurrentMa <= MCT_PEAK_MA[appliedCode]; // RULE14
      lowSideRange <= rangeOfCode; // RULE15
    end
  end

  // ****************************************
  // back-emf sample and hold
  // ****************************************
  // the held value is the last one tracked inside the zero window,
  // so recirculation transients before the window closes are hidden
  logic [BEMF_WIDTH-1:0] trackSample;
  logic [BEMF_WIDTH-1:0] heldSample;
  wire windowEnd = zeroCrossing & ~zeroNow;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zeroCrossing <= 1'b0;
      trackSample <= '0;
      heldSample <= '0;
    end else begin
      zeroCrossing <= zeroNow;
      if (zeroNow) begin
        trackSample <= coilVoltage; // RULE16
      end
      if (windowEnd) begin
        heldSample <= trackSample; // RULE16
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      backemfOutput <= '0;
    end else begin
      backemfOutput <= backemfTransparencyBit ? coilVoltage :
                       heldSample; // RULE17
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic [6:0] trigIndex;
  logic [6:0] trigInc;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trigIndex <= 7'h00;
      trigInc <= 7'h01;
    end else begin
      trigIndex <= translatorIndex;
      trigInc <= newInc;
    end
  end

  index_step_up_a: assert property ( // RULE5
    trigger && !finer && !stepDown |=>
      translatorIndex == 7'(trigIndex + trigInc))
    else $error("index did not advance by one step");

  index_step_down_a: assert property ( // RULE20
    trigger && !finer && stepDown && translatorIndex == 7'h00 &&
    newInc == 7'h01 |=> translatorIndex == 7'h7F)
    else $error("index did not wrap below zero");

  index_hold_a: assert property ( // RULE7
    !trigger |=> $stable(translatorIndex))
    else $error("index moved without a trigger");

  mode_wait_a: assert property ( // RULE8
    !trigger |=> $stable(activeResolution))
    else $error("resolution changed without a trigger");

  fine_grid_a: assert property ( // RULE9
    trigger && finer |=>
      (translatorIndex & 7'(trigInc - 7'h01)) == 7'h00)
    else $error("finer mode left index off its grid");

  edge_polarity_a: assert property ( // RULE6
    armed && stepEdgePolarityBit && stepRise |-> !trigger)
    else $error("rising edge triggered in falling mode");

  direction_xor_a: assert property ( // RULE4
    trigger && !finer && dirLevel == directionControlBit |=>
      translatorIndex == 7'(trigIndex + trigInc))
    else $error("step lost on resolved direction");

  sine_point_a: assert property ( // RULE3
    translatorIndex == 7'h10 && activeResolution != MCT_MODE_HALF_SQ &&
    activeResolution != MCT_MODE_FULL |=>
      coilCurrentX == 11'sh28B && coilCurrentY == 11'sh28B)
    else $error("coil table wrong at index sixteen");

  peak_period_a: assert property ( // RULE13
    !pwmPeriodStart ##1 !pwmPeriodStart |=> $stable(peakCurrentMa))
    else $error("peak current changed inside a period");

  range_top_a: assert property ( // RULE15
    pwmPeriodStart && peakCurrentCode >= MCT_RANGE3_LO |=> ##1
      lowSideRange == 2'h3)
    else $error("top current range not selected");

  bemf_hold_a: assert property ( // RULE17
    !backemfTransparencyBit && !windowEnd ##1 !backemfTransparencyBit
      |=> $stable(backemfOutput))
    else $error("held back-emf changed outside a window end");

  reset_start_a: assert property ( // RULE18
    $rose(rst_n) |-> translatorIndex == 7'h00 &&
      activeResolution == MCT_MODE_32)
    else $error("translator not at origin after reset");

  rise_trigger_a: assert property ( // RULE6
    armed && !stepEdgePolarityBit && stepRise |-> trigger)
    else $error("rising edge missed in rising mode");

  step_pulse_a: assert property ( // RULE7
    trigger |=> stepTaken)
    else $error("step pulse missing after trigger");

  coarse_offset_a: assert property ( // RULE10 RULE11
    trigger && !finer |=> (translatorIndex & 7'(trigInc - 7'h01)) ==
      (trigIndex & 7'(trigInc - 7'h01)))
    else $error("coarse step lost its offset");

  wrap_up_a: assert property ( // RULE20
    trigger && !finer && !stepDown && translatorIndex == 7'h7F &&
    newInc == 7'h01 |=> translatorIndex == 7'h00)
    else $error("index did not wrap above the top");

  square_point_a: assert property ( // RULE19
    (activeResolution == MCT_MODE_HALF_SQ ||
     activeResolution == MCT_MODE_FULL) && translatorIndex == 7'h30 |=>
      coilCurrentX == 11'sh3E8 && coilCurrentY == 11'sh418)
    else $error("square point not at full scale");

  peak_top_a: assert property ( // RULE14
    appliedCode == 5'h1F |=> peakCurrentMa == 10'h320)
    else $error("top code not at full peak current");

  peak_low_a: assert property ( // RULE14
    appliedCode == 5'h01 |=> peakCurrentMa == 10'h01E)
    else $error("lowest code not at its peak current");

  range_zero_a: assert property ( // RULE15
    appliedCode <= 5'h08 |=> lowSideRange == 2'h0)
    else $error("range zero not selected");

  range_one_a: assert property ( // RULE15
    appliedCode inside {[5'h09:5'h0F]} |=> lowSideRange == 2'h1)
    else $error("range one not selected");

  range_two_a: assert property ( // RULE15
    appliedCode inside {[5'h10:5'h16]} |=> lowSideRange == 2'h2)
    else $error("range two not selected");

  bemf_follow_a: assert property ( // RULE17
    backemfTransparencyBit |=> backemfOutput == $past(coilVoltage))
    else $error("transparent back-emf did not follow");

  zero_sample_a: assert property ( // RULE16
    windowEnd |=> heldSample == $past(trackSample))
    else $error("zero window sample not held");

  dir_down_c: cover property (trigger && stepDown);
  step_seen_c: cover property (trigger ##1 stepTaken);
  mode_finer_c: cover property (trigger && finer);
  wrap_c: cover property (
    trigger && translatorIndex == 7'h7F && !stepDown);
  window_c: cover property (windowEnd && !backemfTransparencyBit);

endmodule
`default_nettype wire

// >>> inc/mct_pkg.sv
// Behaviour
// RULE1: position is a 7-bit index counted in finest micro-steps always.
// RULE2: codes 000 to 100 select 1/32 to 1/2; increment 1,2,4,8,16.
// RULE3: each index maps to signed coil X and Y percentages on a sine shape.
// RULE4: rotation direction comes from the direction pin and the direction bit.
// RULE5: each active step edge moves the index one step up or down.
// RULE6: polarity bit picks rising or falling step edge as the trigger.
// RULE7: index is visible to software and updates right after each trigger.
// RULE8: new resolution waits for the next step trigger before acting.
// RULE9: on finer resolution the index snaps to the nearest finer grid point.
// RULE10: coarser resolution on a shared grid point keeps zero offset.
// RULE11: coarser resolution off the grid keeps the offset and steps coarsely.
// RULE12: controller should lower resolution only on shared grid points.
// RULE13: new peak-current code applies at the next PWM period start.
// RULE14: peak code maps to fixed milliamps, 30 mA at 1 up to 800 mA.
// RULE15: codes group into ranges 0-8, 9-15, 16-22, 23-31 for low-side impedance.
// RULE16: back-EMF is sampled at each coil current zero crossing.
// RULE17: transparency bit passes coil voltage; otherwise the held sample shows.
// RULE18: after reset the translator is at index zero in 1/32 mode.
// RULE19: codes 101 and 110 give square half-step and full-step.
// RULE20: index wraps modulo 128 in both directions.
// RULE21: direction pin XOR direction bit; one means decrement.
package mct_pkg;

  typedef enum logic [2:0] {
    MCT_MODE_32 = 3'h0,
    MCT_MODE_16 = 3'h1,
    MCT_MODE_8 = 3'h2,
    MCT_MODE_4 = 3'h3,
    MCT_MODE_2 = 3'h4,
    MCT_MODE_HALF_SQ = 3'h5,
    MCT_MODE_FULL = 3'h6,
    MCT_MODE_BAD = 3'h7
  } mct_mode_type;

  localparam logic [6:0] MCT_INDEX_RESET = 7'h00;
  localparam logic [4:0] MCT_CODE_RESET = 5'h00;
  localparam logic [4:0] MCT_RANGE1_LO = 5'h09;
  localparam logic [4:0] MCT_RANGE2_LO = 5'h10;
  localparam logic [4:0] MCT_RANGE3_LO = 5'h17;
  localparam logic [4:0] MCT_SQUARE_OFF = 5'h10;
  localparam logic [9:0] MCT_FULL_SCALE = 10'h3E8;
  localparam logic [2:0] MCT_ARM_COUNT = 3'h5;

  // quarter sine in tenths of a percent, offsets 0 to 32
  localparam logic [9:0] MCT_SINE_Q [0:32] = '{
    10'h000, 10'h023, 10'h051, 10'h07F, 10'h0AE, 10'h0DD, 10'h10B,
    10'h13A, 10'h15D, 10'h17F, 10'h1AE, 10'h1D1, 10'h1F4, 10'h222,
    10'h245, 10'h268, 10'h28B, 10'h2AE, 10'h2D1, 10'h2F3, 10'h316,
    10'h33A, 10'h351, 10'h368, 10'h37F, 10'h396, 10'h3A2, 10'h3AD,
    10'h3B9, 10'h3C5, 10'h3D1, 10'h3DC, 10'h3E8};

  // peak current in mA per code
  localparam logic [9:0] MCT_PEAK_MA [0:31] = '{
    10'h000, 10'h01E, 10'h02D, 10'h032, 10'h037, 10'h03D, 10'h043,
    10'h04A, 10'h052, 10'h05B, 10'h064, 10'h06E, 10'h07A, 10'h087,
    10'h095, 10'h0A4, 10'h0B5, 10'h0C8, 10'h0DD, 10'h0F4, 10'h10D,
    10'h129, 10'h148, 10'h16A, 10'h190, 10'h1B9, 10'h1E7, 10'h21A,
    10'h252, 10'h290, 10'h2D4, 10'h320};

  function automatic logic [6:0] mct_step_of(input logic [2:0] mode);
    logic [6:0] inc;
    inc = 7'h01;
    unique case (mode)
      3'h0: inc = 7'h01;
      3'h1: inc = 7'h02;
      3'h2: inc = 7'h04;
      3'h3: inc = 7'h08;
      3'h4: inc = 7'h10;
      3'h5: inc = 7'h10;
      3'h6: inc = 7'h20;
      default: inc = 7'h01;
    endcase
    return inc;
  endfunction

endpackage

// >>> inc/mct_coil_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mct_coil_if;
  logic [6:0] index;
  logic [2:0] mode;
  logic signed [10:0] coilX;
  logic signed [10:0] coilY;
  modport lookup(input index, input mode, output coilX, output coilY);
  modport stepper(output index, output mode, input coilX, input coilY);
endinterface
`default_nettype wire

// >>> rtl/mct_sine_lut.sv
`timescale 1ns/1ps
`default_nettype none
module mct_sine_lut (
  // index in, currents out
  mct_coil_if.lookup coil
);
  import mct_pkg::*;

  // ****************************************
  // quadrant folding of the quarter table
  // ****************************************
  wire [1:0] quad = coil.index[6:5];
  wire [4:0] offset = coil.index[4:0];
  wire [5:0] mirror = 6'h20 - {1'b0, offset};
  wire [9:0] magDirect = MCT_SINE_Q[offset];
  wire [9:0] magMirror = MCT_SINE_Q[mirror];
  // square modes drive both coils at full scale between axes
  wire squareMode = (coil.mode == MCT_MODE_HALF_SQ ||
                     coil.mode == MCT_MODE_FULL) &&
                    offset == MCT_SQUARE_OFF; // RULE19
  wire [9:0] magX = squareMode ? MCT_FULL_SCALE :
                    (quad[0] ? magMirror : magDirect); // RULE3
  wire [9:0] magY = squareMode ? MCT_FULL_SCALE :
                    (quad[0] ? magDirect : magMirror); // RULE3
  wire negX = quad[1];
  wire negY = quad[1] ^ quad[0];
  wire signed [10:0] posX = $signed({1'b0, magX});
  wire signed [10:0] posY = $signed({1'b0, magY});

  assign coil.coilX = negX ? -posX : posX;
  assign coil.coilY = negY ? -posY : posY;
endmodule
`default_nettype wire

// >>> verif/mct_step_host.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// controller side: step and direction pins
// ********
module mct_step_host (
  // clock
  input wire logic clk,
  // request
  input wire logic fire,
  input wire logic dirLevel,
  input wire logic fallingActive,
  input wire logic [3:0] gap,
  // pins and status
  output logic stepPin,
  output logic dirPin,
  output logic busy
);
  // the pin rests at the inactive level; direction settles a gap before
  // the edge and stays put after it, so no step sees a moving direction
  initial begin
    stepPin = 1'b0;
    dirPin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      busy = fire;
      @(negedge clk);
      if (busy) begin
        dirPin = dirLevel;
        repeat (gap) @(negedge clk);
        stepPin = ~fallingActive;
        repeat (gap) @(negedge clk);
        stepPin = fallingActive;
        repeat (gap) @(negedge clk);
        busy = 1'b0;
      end else begin
        stepPin = fallingActive;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_mct_translator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mct_translator;
  import mct_pkg::*;
  // ********
  // stimulus and observation
  // ********
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic stepPulseInput, directionPin, busy;
  logic fire = 1'b0;
  logic dirLevel = 1'b0;
  logic [3:0] gap = 4'h4;
  logic [2:0] stepResolutionSelect = 3'h0;
  logic directionControlBit = 1'b0;
  logic stepEdgePolarityBit = 1'b0;
  logic [4:0] peakCurrentCode = 5'h00;
  logic backemfTransparencyBit = 1'b0;
  logic pwmPeriodStart = 1'b0;
  logic [7:0] coilVoltage = 8'h00;
  logic [6:0] translatorIndex;
  mct_mode_type activeResolution;
  logic stepTaken, zeroCrossing;
  logic signed [10:0] coilCurrentX, coilCurrentY;
  logic [9:0] peakCurrentMa;
  logic [1:0] lowSideRange;
  logic [7:0] backemfOutput;
  int errorCnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int taken = 0;
  int t0;

  always #25 clk = ~clk;

  mct_translator #(.BEMF_WIDTH(8)) u_dut (.clk(clk), .rst_n(rst_n),
    .stepPulseInput(stepPulseInput), .directionPin(directionPin),
    .stepResolutionSelect(stepResolutionSelect),
    .directionControlBit(directionControlBit),
    .stepEdgePolarityBit(stepEdgePolarityBit),
    .peakCurrentCode(peakCurrentCode),
    .backemfTransparencyBit(backemfTransparencyBit),
    .pwmPeriodStart(pwmPeriodStart), .coilVoltage(coilVoltage),
    .translatorIndex(translatorIndex),
    .activeResolution(activeResolution), .stepTaken(stepTaken),
    .coilCurrentX(coilCurrentX), .coilCurrentY(coilCurrentY),
    .peakCurrentMa(peakCurrentMa), .lowSideRange(lowSideRange),
    .zeroCrossing(zeroCrossing), .backemfOutput(backemfOutput));

  mct_step_host u_host (.clk(clk), .fire(fire), .dirLevel(dirLevel),
    .fallingActive(stepEdgePolarityBit), .gap(gap),
    .stepPin(stepPulseInput), .dirPin(directionPin), .busy(busy));

  always @(posedge clk) begin
    if (stepTaken === 1'b1) taken++;
  end

  // cut a hang short well above the expected few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errorCnt++;
      results();
    end
  end

  // ********
  // helpers
  // ********
  task chkIndex(input string what, input logic [6:0] exp,
      input logic [6:0] got);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task chkWord(input string what, input logic [10:0] exp,
      input logic [10:0] got);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task chkCoil(input logic [10:0] x, input logic [10:0] y);
    chkWord("coilX", x, coilCurrentX);
    chkWord("coilY", y, coilCurrentY);
  endtask

  task idle(input int c);
    repeat (c) @(negedge clk);
  endtask

  task step(input logic dn);
    int n;
    dirLevel = dn;
    fire = 1'b1;
    @(negedge clk);
    fire = 1'b0;
    for (n = 0; n < 200 && busy !== 1'b0; n++) @(negedge clk);
    idle(3);
  endtask

  // step edges are ignored while the synchroniser refills after reset
  task doReset();
    rst_n = 1'b0;
    idle(8);
    rst_n = 1'b1;
    idle(7);
  endtask

  // ********
  // scenarios
  // ********
  task testReset();
    chkIndex("index", 7'h00, translatorIndex);
    chkWord("mode", 11'h000, {8'h00, activeResolution});
    chkCoil(11'h000, 11'h3E8);
    chkWord("zero", 11'h001, {10'h000, zeroCrossing});
  endtask

  task testModes();
    logic [2:0] md [0:7] = '{3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h4, 3'h3,
      3'h7};
    logic [6:0] ix [0:7] = '{7'h10, 7'h18, 7'h1C, 7'h1E, 7'h1F, 7'h2F,
      7'h38, 7'h40};
    stepResolutionSelect = 3'h4;
    idle(4);
    chkIndex("held index", 7'h00, translatorIndex);
    chkWord("held mode", 11'h000, {8'h00, activeResolution});
    for (int i = 0; i < 8; i++) begin
      stepResolutionSelect = md[i];
      step(1'b0);
      chkIndex("index", ix[i], translatorIndex);
      if (i == 0) chkCoil(11'h28B, 11'h28B);
      if (i == 1) chkCoil(11'h37F, 11'h15D);
    end
  endtask

  task testDirection();
    logic [1:0] cmb [0:3] = '{2'h0, 2'h2, 2'h1, 2'h3};
    logic [6:0] ix [0:3] = '{7'h50, 7'h40, 7'h30, 7'h40};
    stepResolutionSelect = 3'h4;
    gap = 4'h8;
    for (int i = 0; i < 4; i++) begin
      directionControlBit = cmb[i][0];
      step(cmb[i][1]);
      chkIndex("dir index", ix[i], translatorIndex);
    end
    gap = 4'h4;
    directionControlBit = 1'b0;
  endtask

  task testWrap();
    stepResolutionSelect = 3'h0;
    doReset();
    step(1'b1);
    chkIndex("wrap down", 7'h7F, translatorIndex);
    chkCoil(11'h7DD, 11'h3DC);
    step(1'b0);
    chkIndex("wrap up", 7'h00, translatorIndex);
  endtask

  task testSquare();
    stepResolutionSelect = 3'h5;
    step(1'b0);
    chkIndex("half sq", 7'h10, translatorIndex);
    chkCoil(11'h3E8, 11'h3E8);
    stepResolutionSelect = 3'h6;
    step(1'b0);
    chkIndex("full", 7'h30, translatorIndex);
    chkCoil(11'h3E8, 11'h418);
  endtask

  // a polarity swap moves the resting level: that edge must not step
  task testPolarity();
    stepResolutionSelect = 3'h0;
    t0 = taken;
    stepEdgePolarityBit = 1'b1;
    idle(10);
    chkIndex("rise ignored", 7'h30, translatorIndex);
    step(1'b0);
    chkIndex("fall steps", 7'h31, translatorIndex);
    stepEdgePolarityBit = 1'b0;
    idle(10);
    chkIndex("fall ignored", 7'h31, translatorIndex);
    chkWord("pulses", 11'(t0 + 1), 11'(taken));
  endtask

  task testBemf();
    doReset();
    backemfTransparencyBit = 1'b1;
    coilVoltage = 8'h3C;
    idle(2);
    chkWord("follow", 11'h03C, {3'h0, backemfOutput});
    coilVoltage = 8'hC3;
    idle(2);
    chkWord("follow", 11'h0C3, {3'h0, backemfOutput});
    backemfTransparencyBit = 1'b0;
    coilVoltage = 8'h5A;
    idle(3);
    step(1'b0);
    coilVoltage = 8'hA5;
    idle(3);
    chkWord("held", 11'h05A, {3'h0, backemfOutput});
  endtask

  task testPeak();
    logic [4:0] cd [0:7] = '{5'h01, 5'h08, 5'h09, 5'h0F, 5'h10, 5'h16,
      5'h17, 5'h1F};
    logic [9:0] ma [0:7] = '{10'h01E, 10'h052, 10'h05B, 10'h0A4, 10'h0B5,
      10'h148, 10'h16A, 10'h320};
    logic [9:0] prev;
    prev = 10'h000;
    for (int i = 0; i < 8; i++) begin
      peakCurrentCode = cd[i];
      idle(4);
      chkWord("held mA", {1'b0, prev}, {1'b0, peakCurrentMa});
      pwmPeriodStart = 1'b1;
      idle(1);
      pwmPeriodStart = 1'b0;
      idle(3);
      chkWord("mA", {1'b0, ma[i]}, {1'b0, peakCurrentMa});
      chkWord("range", 11'(i / 2), {9'h000, lowSideRange});
      prev = ma[i];
    end
  endtask

  task results();
    $display("comparisons %0d errors %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    doReset();
    testReset();
    testModes();
    testDirection();
    testWrap();
    testSquare();
    testPolarity();
    testBemf();
    testPeak();
    results();
  end
endmodule
`default_nettype wire
